/* include/pll_ctrl_consts.svh */
// Constants for the digital PLL ratio and skip control block.
// Assumes inclusion from the design modules and the testbench only.
`ifndef PLL_CTRL_CONSTS_SVH
`define PLL_CTRL_CONSTS_SVH

// Register offsets on the plain register port.
`define OFS_CONFIG      4'h0
`define OFS_POINTERS    4'h1
`define OFS_STATUS      4'h2
`define OFS_EFF_RATIO   4'h3
`define OFS_SLOT_BASE   4'h4
`define OFS_SLOT_LAST   4'h7

// Configuration field positions.
`define CFG_SKIP_BIT    0
`define CFG_UNLOCK_BIT  1
`define CFG_LFFMT_BIT   2
`define CFG_SRC_BIT     3
`define CFG_BW_LSB      4
`define CFG_SCALE_LSB   8

// Pointer field positions.
`define PTR_STATIC_LSB  0
`define PTR_DYN_LSB     2

// Reset values.
`define CONFIG_RST      32'h0000_0000
`define POINTERS_RST    4'h0
`define SLOT_RST        32'h0000_0000

// Timing figures.
`define SKIP_WINDOW_MS  20
`define CLK_HZ          25000000
`define LOSS_CYCLES     8388608
`define ACQ_CYCLES      65536

`endif

/* include/pll_ctrl_pkg.sv */
// Types for the digital PLL ratio and skip control block.
// Assumes the constants header sits beside it on the include path.
package pll_ctrl_pkg;

   // Lock state of the control loop.
   typedef enum logic [1:0] {
      ST_UNLOCKED = 2'b00,
      ST_ACQUIRE  = 2'b01,
      ST_LOCKED   = 2'b10,
      ST_SKIPPING = 2'b11
   } lock_state_e;

   // Format of the user ratio.
   typedef enum logic {
      FMT_HIGH_RES  = 1'b0,
      FMT_HIGH_MULT = 1'b1
   } ratio_fmt_e;

   // Configuration bits that steer the control logic.
   typedef struct packed {
      logic [2:0] scale_sel;
      logic [2:0] bw_sel;
      logic       synth_source_select;
      logic       low_freq_format_select;
      logic       output_on_unlock_enable;
      logic       skip_tolerance_enable;
   } config_s;

   // Result handed to the synthesizer.
   typedef struct packed {
      logic        dynamic_src;
      ratio_fmt_e  fmt;
      logic [35:0] effective_ratio;
   } synth_cmd_s;

endpackage : pll_ctrl_pkg

/* rtl/ratio_scaler.sv */
// Ratio scaler: applies the power-of-two modifier to the user ratio.
// Assumes a registered ratio input; pure combinational path.
`timescale 1ns/1ps
`include "pll_ctrl_consts.svh"

module ratio_scaler
   import pll_ctrl_pkg::*;
(
   // Inputs.
   input  wire logic [31:0] user_ratio_i,
   input  wire logic [2:0]  scale_sel_i,
   // Output, four fraction bits added below the stored LSB.
   output logic      [35:0] effective_ratio_o
);

   // -----------------------------------------------------------------
   // Scaling
   // -----------------------------------------------------------------

   // Widened by three bits above and four below so no selection
   // truncates; overflow checking is left to software.
   logic [38:0] wide;

   // The stored slot is never touched; only this copy is shifted.
   always_comb begin
      wide = {3'h0, user_ratio_i, 4'h0};
      unique case (scale_sel_i)
         3'b000: wide = {3'h0, user_ratio_i, 4'h0};
         3'b001: wide = {2'h0, user_ratio_i, 5'h00};
         3'b010: wide = {1'h0, user_ratio_i, 6'h00};
         3'b011: wide = {user_ratio_i, 7'h00};
         3'b100: wide = {4'h0, user_ratio_i, 3'h0};
         3'b101: wide = {5'h00, user_ratio_i, 2'h0};
         3'b110: wide = {6'h00, user_ratio_i, 1'h0};
         3'b111: wide = {7'h00, user_ratio_i};
      endcase
   end

   // Drop the top bits; a legal ratio never reaches them.
   assign effective_ratio_o = wide[35:0];

endmodule : ratio_scaler

/* rtl/pll_ratio_skip_ctrl.sv */
// Control logic of the hybrid digital PLL: reference watch, lock state,
// loop bandwidth, ratio slots, format and source selection.
// Assumes clk_i is the internal timing clock at 25 MHz and freq_ref_i is
// an asynchronous pin from the frequency reference source.
//
// Operation
// - With skip enabled, lock holds across reference gaps up to 20 ms.
// - Skip behaviour acts only while skip_tolerance_enable is set.
// - After clean loss, output continues for 2^23 timing clock cycles.
// - Glitch or period change on removal unlocks immediately.
// - On timeout, unlock; output follows output_on_unlock_enable.
// - Reference back after timeout: unlocked for acquisition time, then lock.
// - Skip off, short gap: output continues, unlocked only while relocking.
// - Skip on, short gap: output continuous throughout and while relocking.
// - Three-bit min_loop_bw_select sets minimum bandwidth 1 Hz to 128 Hz.
// - Wide bandwidth while acquiring, selected minimum once locked.
// - Four ratio slots; static pointer picks active slot in static mode.
// - High-resolution format is unsigned 12.20.
// - Internal dividers compensated; ratio is plain output-to-input.
// - Hybrid mode picks slot by dynamic_ratio_pointer from same slots.
// - High-multiplication format is 20.12.
// - 20.12 only when format bit clear and dynamic source chosen.
// - Auto source with reference absent forces 12.20.
// - Scaler always applied internally; stored slots stay unchanged.
// - Scaler codes 1,2,4,8,0.5,0.25,0.125,0.0625; reset to 000.
// - Effective ratio is user ratio times scaler.
// - Pointers differ: auto source, reference presence decides.
// - Unlocked output held low unless output_on_unlock_enable is set.
//
// Design decisions made here: strobed register access and the address map.
`timescale 1ns/1ps
`include "pll_ctrl_consts.svh"

module pll_ratio_skip_ctrl
   import pll_ctrl_pkg::*;
#(
   parameter int unsigned LOSS_CYCLES = `LOSS_CYCLES,
   parameter int unsigned ACQ_CYCLES  = `ACQ_CYCLES
) (
   // Clock and reset.
   input  wire logic        clk_i,
   input  wire logic        rst_n_i,
   // Register port.
   input  wire logic [3:0]  addr_i,
   input  wire logic [31:0] wdata_i,
   input  wire logic        wr_i,
   input  wire logic        rd_i,
   output logic      [31:0] rdata_o,
   // Frequency reference pin and synthesizer clock.
   input  wire logic        freq_ref_i,
   input  wire logic        synth_clk_i,
   // Synthesizer control.
   output synth_cmd_s       synth_cmd_o,
   output logic      [2:0]  loop_bw_o,
   output logic             wide_bw_o,
   output logic             locked_o,
   output logic             clk_out_o
);

   // -----------------------------------------------------------------
   // Timing
   // -----------------------------------------------------------------

   // Skip window in cycles, a longest time so it rounds down.
   localparam int unsigned SKIP_CYCLES =
      (`SKIP_WINDOW_MS * (`CLK_HZ / 1000));
   // Bandwidth code used while lock is being acquired.
   localparam logic [2:0] BW_WIDE = 3'h7;

   // -----------------------------------------------------------------
   // Registers
   // -----------------------------------------------------------------

   config_s     cfg_r;
   logic [1:0]  static_ptr_r;
   logic [1:0]  dyn_ptr_r;
   logic [31:0] slot_r [4];

   // Configuration writes; scaler resets to 000.
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cfg_r <= config_s'(`CONFIG_RST);
      end else if (wr_i && addr_i == `OFS_CONFIG) begin
         cfg_r.skip_tolerance_enable   <= wdata_i[`CFG_SKIP_BIT];
         cfg_r.output_on_unlock_enable <= wdata_i[`CFG_UNLOCK_BIT];
         cfg_r.low_freq_format_select  <= wdata_i[`CFG_LFFMT_BIT];
         cfg_r.synth_source_select     <= wdata_i[`CFG_SRC_BIT];
         cfg_r.bw_sel    <= wdata_i[`CFG_BW_LSB +: 3];
         cfg_r.scale_sel <= wdata_i[`CFG_SCALE_LSB +: 3];
      end
   end

   // Ratio pointers.
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         static_ptr_r <= 2'(`POINTERS_RST >> `PTR_STATIC_LSB);
         dyn_ptr_r    <= 2'(`POINTERS_RST >> `PTR_DYN_LSB);
      end else if (wr_i && addr_i == `OFS_POINTERS) begin
         static_ptr_r <= wdata_i[`PTR_STATIC_LSB +: 2];
         dyn_ptr_r    <= wdata_i[`PTR_DYN_LSB +: 2];
      end
   end

   // Four ratio slots, one per index.
   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++) begin : g_slot
         always_ff @(posedge clk_i or negedge rst_n_i) begin
            if (!rst_n_i) begin
               slot_r[gi] <= `SLOT_RST;
            end else if (wr_i && addr_i == (`OFS_SLOT_BASE + 4'(gi))) begin
               slot_r[gi] <= wdata_i;
            end
         end
      end
   endgenerate

   // -----------------------------------------------------------------
   // Reference input
   // -----------------------------------------------------------------

   // Two flops before anything reads the pin; a third gives edges.
   logic ref_s1_r;
   logic ref_s2_r;
   logic ref_d_r;
   logic ref_edge;

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         ref_s1_r <= 1'b0;
         ref_s2_r <= 1'b0;
         ref_d_r  <= 1'b0;
      end else begin
         ref_s1_r <= freq_ref_i;
         ref_s2_r <= ref_s1_r;
         ref_d_r  <= ref_s2_r;
      end
   end

   assign ref_edge = ref_s2_r && !ref_d_r;

   // -----------------------------------------------------------------
   // Period watch
   // -----------------------------------------------------------------

   // Counter since last edge and the last measured period. Saturates
   // at the loss count so a dead reference never wraps around.
   logic [23:0] gap_r;
   logic [23:0] period_r;
   logic        period_ok_r;
   logic        ref_lost;
   logic        gap_long;
   logic        glitch;
   lock_state_e state_r;

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         gap_r <= 24'(LOSS_CYCLES);       // Starts as lost: no bogus period.
      end else if (ref_edge) begin
         gap_r <= 24'h00_0000;
      end else if (gap_r < 24'(LOSS_CYCLES)) begin
         gap_r <= gap_r + 24'h00_0001;
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         period_r    <= 24'h00_0000;
         period_ok_r <= 1'b0;
      end else if (ref_edge && state_r != ST_SKIPPING) begin
         // An edge that closes a gap spans missed pulses, not a period.
         period_r    <= gap_r;
         period_ok_r <= !ref_lost;
      end else if (ref_lost) begin
         period_ok_r <= 1'b0;
      end
   end

   assign ref_lost = (gap_r >= 24'(LOSS_CYCLES));
   // Silence beyond the skip window.
   assign gap_long = (gap_r > 24'(SKIP_CYCLES));
   // An edge too early against the last period is a glitch or new rate.
   assign glitch = ref_edge && period_ok_r &&
                   (gap_r < (period_r - (period_r >> 2)));

   // The reference counts as present from its first edge until it is lost
   // or silent beyond the skip window.
   logic ref_present;
   assign ref_present = !ref_lost && !gap_long;

   // -----------------------------------------------------------------
   // Lock state
   // -----------------------------------------------------------------

   logic [23:0] acq_r;
   logic        out_hold_r;

   // Reference missing with a stable prior rate means a gap has begun.
   logic gap_start;
   assign gap_start = period_ok_r && (gap_r > period_r + (period_r >> 2));

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state_r <= ST_UNLOCKED;
         acq_r   <= 24'h00_0000;
      end else begin
         unique case (state_r)
            ST_UNLOCKED: begin
               acq_r <= 24'h00_0000;
               if (ref_edge) begin
                  state_r <= ST_ACQUIRE;
               end
            end
            ST_ACQUIRE: begin
               if (glitch || ref_lost) begin
                  state_r <= ST_UNLOCKED;
               end else if (acq_r >= 24'(ACQ_CYCLES - 1)) begin
                  state_r <= ST_LOCKED;
               end else begin
                  acq_r <= acq_r + 24'h00_0001;
               end
            end
            ST_LOCKED: begin
               if (glitch) begin
                  state_r <= ST_UNLOCKED;
               end else if (ref_lost) begin
                  state_r <= ST_UNLOCKED;
               end else if (gap_start) begin
                  state_r <= ST_SKIPPING;
               end
            end
            ST_SKIPPING: begin
               acq_r <= 24'h00_0000;
               if (ref_lost) begin
                  state_r <= ST_UNLOCKED;
               end else if (ref_edge) begin
                  // Short gap with skip on keeps lock; otherwise relock.
                  if (cfg_r.skip_tolerance_enable && !gap_long) begin
                     state_r <= ST_LOCKED;
                  end else begin
                     state_r <= ST_ACQUIRE;
                  end
               end
            end
         endcase
      end
   end

   // Output keeps running across a gap until the reference returns.
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         out_hold_r <= 1'b0;
      end else begin
         out_hold_r <= (state_r == ST_LOCKED) || (state_r == ST_SKIPPING);
      end
   end

   assign locked_o  = out_hold_r;
   // Acquisition runs wide; lock settles to the selected minimum.
   assign wide_bw_o = (state_r != ST_LOCKED);
   assign loop_bw_o = wide_bw_o ? BW_WIDE : cfg_r.bw_sel;
   // Static low while unlocked unless the override is set.
   assign clk_out_o = synth_clk_i &&
                      (out_hold_r || cfg_r.output_on_unlock_enable);

   // -----------------------------------------------------------------
   // Ratio selection
   // -----------------------------------------------------------------

   logic       auto_src;
   logic       dyn_src;
   ratio_fmt_e fmt;
   logic [35:0] eff_ratio;

   assign auto_src = (dyn_ptr_r != static_ptr_r);
   assign dyn_src  = auto_src ? ref_present
                              : cfg_r.synth_source_select;

   // 20.12 only with dynamic source and the format bit clear; an
   // absent reference in auto mode drops to static and thus 12.20.
   assign fmt = (dyn_src && !cfg_r.low_freq_format_select)
                ? FMT_HIGH_MULT : FMT_HIGH_RES;

   // Ratio is plain output-to-input; divider correction lives downstream.
   ratio_scaler u_scaler (
      .user_ratio_i      (dyn_src ? slot_r[dyn_ptr_r]
                                  : slot_r[static_ptr_r]),
      .scale_sel_i       (cfg_r.scale_sel),
      .effective_ratio_o (eff_ratio)
   );

   // Registered command to the synthesizer.
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         synth_cmd_o <= '0;
      end else begin
         synth_cmd_o.dynamic_src     <= dyn_src;
         synth_cmd_o.fmt             <= fmt;
         synth_cmd_o.effective_ratio <= eff_ratio;
      end
   end

   // -----------------------------------------------------------------
   // Read port
   // -----------------------------------------------------------------

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rdata_o <= 32'h0000_0000;
      end else if (rd_i) begin
         if (addr_i == `OFS_CONFIG) begin
            rdata_o <= {20'h0_0000, 1'b0, cfg_r.scale_sel, 1'b0,
                        cfg_r.bw_sel, cfg_r.synth_source_select,
                        cfg_r.low_freq_format_select,
                        cfg_r.output_on_unlock_enable,
                        cfg_r.skip_tolerance_enable};
         end else if (addr_i == `OFS_POINTERS) begin
            rdata_o <= {28'h000_0000, dyn_ptr_r, static_ptr_r};
         end else if (addr_i == `OFS_STATUS) begin
            rdata_o <= {26'h000_0000, fmt, dyn_src, ref_present,
                        wide_bw_o, state_r};
         end else if (addr_i == `OFS_EFF_RATIO) begin
            rdata_o <= eff_ratio[35:4];
         end else if (addr_i >= `OFS_SLOT_BASE &&
                      addr_i <= `OFS_SLOT_LAST) begin
            rdata_o <= slot_r[addr_i[1:0]];
         end else begin
            rdata_o <= 32'h0000_0000;
         end
      end else begin
         rdata_o <= 32'h0000_0000;
      end
   end

endmodule : pll_ratio_skip_ctrl

/* verif/pll_ctrl_checker.sv */
// Concurrent checks on the PLL ratio and skip control top module.
// Assumes it is bound to that module and sees its ports only.
`timescale 1ns/1ps

module pll_ctrl_checker
   import pll_ctrl_pkg::*;
#(
   parameter int unsigned LOSS_CYCLES = 4000,
   parameter int unsigned ACQ_CYCLES  = 16
) (
   // Clock, reset and register port.
   input  wire logic        clk_i,
   input  wire logic        rst_n_i,
   input  wire logic [3:0]  addr_i,
   input  wire logic [31:0] wdata_i,
   input  wire logic        wr_i,
   input  wire logic        rd_i,
   input  wire logic [31:0] rdata_o,
   // Reference pin and synthesizer side.
   input  wire logic        freq_ref_i,
   input  wire logic        synth_clk_i,
   input  wire synth_cmd_s  synth_cmd_o,
   input  wire logic [2:0]  loop_bw_o,
   input  wire logic        wide_bw_o,
   input  wire logic        locked_o,
   input  wire logic        clk_out_o
);
   logic [10:0] cfg_r;
   logic [3:0]  ptr_r;
   logic        ref_r;
   logic [31:0] gap_r;
   logic [31:0] low_r;

   // Shadows of the words software wrote, plus cycles since the last raw
   // reference rise and cycles out of lock; figures allow sync slack.
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cfg_r <= 11'h000;
         ptr_r <= 4'h0;
         ref_r <= 1'b0;
         gap_r <= 32'h0000_0000;
         low_r <= 32'h0000_0000;
      end else begin
         if (wr_i && addr_i == 4'h0) cfg_r <= wdata_i[10:0];
         if (wr_i && addr_i == 4'h1) ptr_r <= wdata_i[3:0];
         ref_r <= freq_ref_i;
         gap_r <= (freq_ref_i && !ref_r) ? 32'h0000_0000
                                         : gap_r + 32'h0000_0001;
         low_r <= locked_o ? 32'h0000_0000 : low_r + 32'h0000_0001;
      end
   end

   default clocking dc @(posedge clk_i);
   endclocking
   default disable iff (!rst_n_i);

   bw_min_sel_a: assert property (
      !wide_bw_o |-> loop_bw_o == cfg_r[6:4])
      else $error("locked bandwidth is not the selected minimum");
   narrow_when_locked_a: assert property (
      !wide_bw_o |=> locked_o)
      else $error("narrow bandwidth without lock");
   clk_gate_a: assert property (
      clk_out_o == (synth_clk_i & (locked_o | cfg_r[1])))
      else $error("output clock gating wrong");
   loss_bound_a: assert property (
      gap_r == LOSS_CYCLES + 12 |-> !locked_o)
      else $error("still locked after loss count");
   loss_early_a: assert property (
      $fell(locked_o) && gap_r > LOSS_CYCLES / 4 |-> gap_r >= LOSS_CYCLES)
      else $error("lock dropped before full loss count");
   acq_time_a: assert property (
      $rose(locked_o) |-> low_r >= ACQ_CYCLES - 1)
      else $error("lock reached before acquisition time");
   skip_hold_a: assert property (
      $fell(locked_o) && cfg_r[0] |-> gap_r < 12 || gap_r >= LOSS_CYCLES)
      else $error("lock dropped in a skip gap");
   manual_src_a: assert property (
      ptr_r[1:0] == ptr_r[3:2] && $stable(ptr_r) && $stable(cfg_r)
      |-> synth_cmd_o.dynamic_src == cfg_r[3]
          && synth_cmd_o.fmt == (cfg_r[3] & ~cfg_r[2]))
      else $error("manual source or format wrong");
   high_res_a: assert property (
      cfg_r[2] && $past(cfg_r[2]) |-> synth_cmd_o.fmt == FMT_HIGH_RES)
      else $error("format not high resolution");
endmodule : pll_ctrl_checker

bind pll_ratio_skip_ctrl pll_ctrl_checker #(
   .LOSS_CYCLES(LOSS_CYCLES), .ACQ_CYCLES(ACQ_CYCLES)) u_chk (
   .clk_i(clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
   .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .freq_ref_i(freq_ref_i),
   .synth_clk_i(synth_clk_i), .synth_cmd_o(synth_cmd_o),
   .loop_bw_o(loop_bw_o), .wide_bw_o(wide_bw_o), .locked_o(locked_o),
   .clk_out_o(clk_out_o));

/* verif/ref_source_model.sv */
// Frequency reference source feeding the control block's reference pin.
// Assumes the bench sets run, period and early-edge controls per cycle.
`timescale 1ns/1ps

module ref_source_model (
   // Clock and reset.
   input  wire logic        clk_i,
   input  wire logic        rst_n_i,
   // Controls from the bench.
   input  wire logic        run_i,
   input  wire logic [15:0] period_i,
   input  wire logic        early_i,
   // Reference pin.
   output logic             ref_o
);
   logic [15:0] cnt_r;

   // One pulse per period, the first at once; early_i cuts the period to a
   // quarter to mimic a glitch. A removed source rests low, as a stopped
   // oscillator output does.
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cnt_r <= 16'h0000;
      end else if (!run_i) begin
         cnt_r <= 16'h0000;
      end else if (cnt_r >= (early_i ? period_i >> 2 : period_i) - 1) begin
         cnt_r <= 16'h0000;
      end else begin
         cnt_r <= cnt_r + 16'h0001;
      end
   end

   assign ref_o = run_i && (cnt_r < 16'h0008);
endmodule : ref_source_model

/* verif/pll_ratio_skip_ctrl_tb.sv */
// Self-checking bench for the PLL ratio and skip control block.
// Assumes the reference model and the bound checker are compiled first.
`timescale 1ns/1ps
`include "pll_ctrl_consts.svh"

module pll_ratio_skip_ctrl_tb;
   import pll_ctrl_pkg::*;
   localparam int unsigned LOSS = 4000;
   localparam int unsigned ACQ  = 16;
   localparam logic [35:0] ONE  = 36'h0_0000_0001;
   logic        clk_i, rst_n_i, wr_i, rd_i, synth_clk_i, run, early, ref_w;
   logic [3:0]  addr_i;
   logic [31:0] wdata_i, rdata_o, slot [4];
   logic [35:0] e;
   logic [2:0]  loop_bw_o;
   logic        wide_bw_o, locked_o, clk_out_o;
   synth_cmd_s  synth_cmd_o;
   int          num_errors, compares, n, k, lowc;
   int          cyc = 0;

   pll_ratio_skip_ctrl #(.LOSS_CYCLES(LOSS), .ACQ_CYCLES(ACQ)) u_dut (
      .clk_i(clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
      .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .freq_ref_i(ref_w),
      .synth_clk_i(synth_clk_i), .synth_cmd_o(synth_cmd_o),
      .loop_bw_o(loop_bw_o), .wide_bw_o(wide_bw_o), .locked_o(locked_o),
      .clk_out_o(clk_out_o));
   // Period of 400 cycles keeps the reference at 62.5 kHz.
   ref_source_model u_ref (.clk_i(clk_i), .rst_n_i(rst_n_i), .run_i(run),
      .period_i(16'h0190), .early_i(early), .ref_o(ref_w));

   // Timing clock, and a synthesizer clock at half its rate.
   initial begin
      clk_i = 1'b0;
      forever #20 clk_i = ~clk_i;
   end
   always @(posedge clk_i) synth_clk_i <= (synth_clk_i !== 1'b1);

   // A hang is cut short well beyond the longest expected run.
   always @(posedge clk_i) begin
      cyc <= cyc + 1;
      if (cyc == 30000) begin
         num_errors++;
         $display("mismatch at %0t: run timed out", $time);
         summarize();
      end
   end

   task automatic summarize();
      if (num_errors == 0 && compares > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : summarize

   task automatic chk(input logic [35:0] got, input logic [35:0] exp);
      compares++;
      if (got !== exp) begin
         num_errors++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk_i);
      addr_i  <= a;
      wdata_i <= d;
      wr_i    <= 1'b1;
      @(posedge clk_i);
      wr_i    <= 1'b0;
   endtask : wr

   // Read data stand only in the cycle after the strobe.
   task automatic rd(input logic [3:0] a, input logic [31:0] exp);
      @(posedge clk_i);
      addr_i <= a;
      rd_i   <= 1'b1;
      @(posedge clk_i);
      rd_i   <= 1'b0;
      #1 chk({4'h0, rdata_o}, {4'h0, exp});
   endtask : rd

   task automatic wait_lk(input logic want, input int lim);
      n = 0;
      while (locked_o !== want && n < lim) begin
         @(posedge clk_i);
         #1 n++;
      end
      chk(36'(locked_o), 36'(want));
   endtask : wait_lk

   task automatic watch(input int len);
      repeat (len) begin
         @(posedge clk_i);
         #1 if (locked_o !== 1'b1) lowc++;
      end
   endtask : watch

   // Removes the reference for len cycles, then restores it and counts
   // the cycles spent out of lock while it settles.
   task automatic gap(input int len);
      @(negedge ref_w);
      @(posedge clk_i);
      run  <= 1'b0;
      lowc = 0;
      watch(len);
      chk(36'(lowc), 36'h0_0000_0000);
      @(posedge clk_i);
      run  <= 1'b1;
      lowc = 0;
      watch(ACQ * 10);
   endtask : gap

   initial begin
      {rst_n_i, wr_i, rd_i, run, early} = 5'h00;
      addr_i = 4'h0;
      wdata_i = 32'h0000_0000;
      num_errors = 0;
      compares = 0;
      repeat (2) @(posedge clk_i);
      rst_n_i <= 1'b1;
      rd(`OFS_CONFIG, 32'h0000_0000);
      rd(`OFS_POINTERS, 32'h0000_0000);
      rd(`OFS_STATUS, 32'h0000_0004);
      chk(36'(clk_out_o), 36'h0_0000_0000);
      for (k = 0; k < 4; k++) begin
         rd(`OFS_SLOT_BASE + 4'(k), 32'h0000_0000);
         slot[k] = 32'h0012_3450 + 32'(k) * 32'h0010_0000;
         wr(`OFS_SLOT_BASE + 4'(k), slot[k]);
      end
      // An unmapped index must read zero, not alias a slot.
      wr(4'h8, 32'hFFFF_FFFF);
      rd(4'h8, 32'h0000_0000);
      // Every scaler code applied to one stored ratio.
      for (k = 0; k < 8; k++) begin
         wr(`OFS_CONFIG, {21'h0, 3'(k), 8'h00});
         e = {slot[0], 4'h0};
         e = (k > 3) ? e >> (k - 3) : e << k;
         rd(`OFS_EFF_RATIO, e[35:4]);
         chk(synth_cmd_o.effective_ratio, e);
         rd(`OFS_SLOT_BASE, slot[0]);
      end
      wr(`OFS_CONFIG, 32'h0000_0000);
      for (k = 0; k < 4; k++) begin
         wr(`OFS_POINTERS, {28'h0, 2'(k), 2'(k)});
         rd(`OFS_EFF_RATIO, slot[k]);
      end
      wr(`OFS_CONFIG, 32'h0000_0008);
      repeat (2) @(posedge clk_i);
      #1 chk(36'(synth_cmd_o.fmt), 36'(FMT_HIGH_MULT));
      wr(`OFS_CONFIG, 32'h0000_000C);
      repeat (2) @(posedge clk_i);
      #1 chk(36'(synth_cmd_o.fmt), 36'(FMT_HIGH_RES));
      // Pointers differ: reference presence picks the source.
      wr(`OFS_CONFIG, 32'h0000_0058);
      wr(`OFS_POINTERS, 32'h0000_0009);
      rd(`OFS_EFF_RATIO, slot[1]);
      chk(36'(synth_cmd_o.dynamic_src), 36'h0_0000_0000);
      chk(36'(synth_cmd_o.fmt), 36'(FMT_HIGH_RES));
      chk(36'(loop_bw_o), 36'h0_0000_0007);
      @(posedge clk_i);
      run <= 1'b1;
      wait_lk(1'b1, 300);
      chk(36'(n >= ACQ), ONE);
      rd(`OFS_EFF_RATIO, slot[2]);
      chk(36'(synth_cmd_o.dynamic_src), ONE);
      for (k = 0; k < 8; k++) begin
         wr(`OFS_CONFIG, {25'h0, 3'(k), 4'h8});
         #1 chk(36'(loop_bw_o), 36'(k));
      end
      wr(`OFS_CONFIG, 32'h0000_0059);
      gap(1200);
      chk(36'(lowc), 36'h0_0000_0000);
      wr(`OFS_CONFIG, 32'h0000_0058);
      gap(1200);
      chk(36'(lowc >= ACQ && lowc <= ACQ + 12), ONE);
      // Long loss with the output left running while unlocked.
      wr(`OFS_CONFIG, 32'h0000_005A);
      @(negedge ref_w);
      @(posedge clk_i);
      run <= 1'b0;
      wait_lk(1'b0, LOSS + 100);
      chk(36'(n + 12 >= LOSS && n <= LOSS + 8), ONE);
      chk(36'(clk_out_o), 36'(synth_clk_i));
      @(posedge clk_i);
      run <= 1'b1;
      wait_lk(1'b1, ACQ * 20);
      chk(36'(n >= ACQ), ONE);
      // A short period as the source goes away unlocks at once.
      wr(`OFS_CONFIG, 32'h0000_0059);
      @(negedge ref_w);
      @(posedge clk_i);
      early <= 1'b1;
      @(negedge ref_w);
      @(posedge clk_i);
      early <= 1'b0;
      run   <= 1'b0;
      wait_lk(1'b0, 20);
      summarize();
   end
endmodule : pll_ratio_skip_ctrl_tb
